// ==== upr_map.vh ====
`ifndef UPR_MAP_VH
`define UPR_MAP_VH

// register byte offsets
`define UPR_MODE_OFS 12'h000
`define UPR_SETUP_LO_OFS 12'h004
`define UPR_SETUP_HI_OFS 12'h008
`define UPR_PORT_SEL_OFS 12'h010
`define UPR_PIPE_CTRL_OFS 12'h040
`define UPR_PIPE_MAX_PACKET_FIELD_OFS 12'h080
`define UPR_PIPE_BUF_OFS 12'h0c0
`define UPR_GROUP_MASK 12'hfe0
`define UPR_PORT_MASK 12'hff0

// response setting encodings
`define UPR_PID_NAK 2'h0
`define UPR_PID_BUF 2'h1
`define UPR_PID_STALL 2'h2

// pipe control register fields
`define UPR_CTRL_SEQUENCE_CLEAR_BIT 2
`define UPR_CTRL_SEQUENCE_SET_BIT 3
`define UPR_CTRL_SEQUENCE_MONITOR_BIT 4
`define UPR_CTRL_AUTONAK_BIT 5
`define UPR_CTRL_ISO_BIT 6
`define UPR_CTRL_BSTATE_BIT 7

// buffer register fields
`define UPR_BUF_COUNT_LSB 10
`define UPR_BLOCK_SHIFT 6

// serial engine event codes
`define UPR_EV_SETUP 4'h0
`define UPR_EV_IN_TOKEN 4'h1
`define UPR_EV_OUT_DATA 4'h2
`define UPR_EV_ACK_RCVD 4'h3
`define UPR_EV_STALL_RCVD 4'h4
`define UPR_EV_NO_REPLY 4'h5
`define UPR_EV_BAD_PACKET 4'h6
`define UPR_EV_OVERSIZE 4'h7
`define UPR_EV_COUNT_END 4'h8
`define UPR_EV_STAGE_ERR 4'h9
`define UPR_EV_STATUS_IN 4'ha
`define UPR_EV_HOST_RX_OK 4'hb

// reply codes to the serial engine
`define UPR_RSP_NONE 3'h0
`define UPR_RSP_ACK 3'h1
`define UPR_RSP_NAK 3'h2
`define UPR_RSP_STALL 3'h3
`define UPR_RSP_DATA 3'h4
`define UPR_RSP_ZLP 3'h5

`endif

// ==== upr_pipe_ctrl.v ====
// Functional notes
// - zero-size bulk IN: blocked buffer, ZLP, no events
// - zero-size bulk OUT: NAK, not-ready only
// - host: NAK/STALL pipes issue no transactions
// - peripheral: NAK/STALL fixed, buffer-driven follows status
// - peripheral: SETUP always ACKed, request captured
// - host: no reply or bad packet forces NAK, iso pipes excepted
// - bulk: auto-NAK on short packet or count end
// - host: STALL handshake or oversize forces STALL
// - peripheral: good SETUP sets control pipe NAK
// - peripheral: oversize or stage error forces STALL
// - sequence toggles on each acknowledged transfer, except data received on iso pipes
// - control: DATA0 after setup, DATA1 status
// - sequence set ignored on isochronous pipes
// - buffer in 64-byte blocks, start and count
// - three FIFO ports with pipe select, ready
`timescale 1ns/1ps
`default_nettype none
`include "upr_map.vh"

module upr_pipe_ctrl #(
  parameter NUM_PORTS = 3,
  parameter MAX_PACKET_FIELD_W = 11
) (
  input wire ref_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sie_evt_valid,
  input wire [3:0] sie_evt_code,
  input wire [2:0] sie_evt_pipe,
  input wire sie_short_pkt,
  input wire [63:0] sie_setup_data,
  input wire [7:0] buf_sie_ready,
  input wire [7:0] buf_cpu_ready,
  output reg [2:0] rsp_code,
  output reg rsp_seq,
  output reg rsp_store,
  output reg ready_evt,
  output reg not_ready_evt,
  output reg empty_evt,
  output reg [7:0] host_pipe_enable,
  output reg [7:0] cpu_write_block,
  output reg [NUM_PORTS-1:0] port_access_ready
);

  reg host_mode_reg;
  reg [63:0] setup_reg;
  reg [1:0] pid_reg [0:7];
  reg [7:0] seq_reg;
  reg [7:0] auto_nak_reg;
  reg [7:0] iso_reg;
  reg [MAX_PACKET_FIELD_W-1:0] max_packet_field_reg [0:7];
  reg [6:0] start_blk_reg [0:7];
  reg [4:0] blk_cnt_reg [0:7];
  reg [2:0] port_pipe_reg [0:NUM_PORTS-1];
  integer i;

  // pipes 1-2 may be isochronous, 1-5 bulk otherwise, 6-7 interrupt
  function is_iso;
    input [2:0] p;
    input [7:0] iso;
    begin
      is_iso = (p == 3'h1 || p == 3'h2) && iso[p];
    end
  endfunction

  function is_bulk;
    input [2:0] p;
    input [7:0] iso;
    begin
      is_bulk = (p >= 3'h1) && (p <= 3'h5) && !is_iso(p, iso);
    end
  endfunction

  wire acc_setup = psel && !penable && !pready;
  wire acc_done = psel && penable && pready;
  wire [2:0] a_pipe = paddr[4:2];
  wire [1:0] a_port = paddr[3:2];
  wire in_mode = paddr == `UPR_MODE_OFS;
  wire in_slo = paddr == `UPR_SETUP_LO_OFS;
  wire in_shi = paddr == `UPR_SETUP_HI_OFS;
  wire in_port = ((paddr & `UPR_PORT_MASK) == `UPR_PORT_SEL_OFS) && (a_port < NUM_PORTS);
  wire in_ctrl = (paddr & `UPR_GROUP_MASK) == `UPR_PIPE_CTRL_OFS;
  wire in_max_packet_field = (paddr & `UPR_GROUP_MASK) == `UPR_PIPE_MAX_PACKET_FIELD_OFS;
  wire in_buf = (paddr & `UPR_GROUP_MASK) == `UPR_PIPE_BUF_OFS;
  wire mapped = in_mode || in_slo || in_shi || in_port || in_ctrl || in_max_packet_field || in_buf;
  wire [2:0] sel_port_pipe = port_pipe_reg[a_port];

  // apb: one access cycle, data and error prepared at the setup edge
  always @(posedge ref_clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= acc_setup;
      pslverr <= acc_setup && !mapped;
      if (acc_setup) begin
        if (in_mode)
          prdata <= {31'h0, host_mode_reg};
        else if (in_slo)
          prdata <= setup_reg[31:0];
        else if (in_shi)
          prdata <= setup_reg[63:32];
        else if (in_port)
          prdata <= {9'h0, start_blk_reg[sel_port_pipe], 7'h0,
                     buf_cpu_ready[sel_port_pipe], 5'h0, sel_port_pipe};
        else if (in_ctrl)
          prdata <= {24'h0, buf_cpu_ready[a_pipe], iso_reg[a_pipe], auto_nak_reg[a_pipe],
                     seq_reg[a_pipe], 2'h0, pid_reg[a_pipe]};
        else if (in_max_packet_field)
          prdata <= {{(32-MAX_PACKET_FIELD_W){1'b0}}, max_packet_field_reg[a_pipe]};
        else if (in_buf)
          prdata <= {17'h0, blk_cnt_reg[a_pipe], 3'h0, start_blk_reg[a_pipe]};
        else
          prdata <= 32'h0;
      end
    end
  end

  wire [2:0] ep = sie_evt_pipe;
  wire [1:0] ep_pid = pid_reg[ep];
  wire ep_bulk = is_bulk(ep, iso_reg);
  wire ep_iso = is_iso(ep, iso_reg);
  wire ep_zero = ep_bulk && (max_packet_field_reg[ep] == {MAX_PACKET_FIELD_W{1'b0}});
  wire ep_ready = buf_sie_ready[ep];
  wire sw_wr = acc_done && pwrite && !pslverr;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      host_mode_reg <= 1'b0;
      setup_reg <= 64'h0;
      seq_reg <= 8'h0;
      auto_nak_reg <= 8'h0;
      iso_reg <= 8'h0;
      rsp_code <= `UPR_RSP_NONE;
      rsp_seq <= 1'b0;
      rsp_store <= 1'b0;
      ready_evt <= 1'b0;
      not_ready_evt <= 1'b0;
      empty_evt <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        pid_reg[i] <= `UPR_PID_NAK;
        max_packet_field_reg[i] <= {MAX_PACKET_FIELD_W{1'b0}};
        start_blk_reg[i] <= 7'h0;
        blk_cnt_reg[i] <= 5'h0;
      end
      for (i = 0; i < NUM_PORTS; i = i + 1)
        port_pipe_reg[i] <= 3'h0;
    end else begin
      // software side first, so a same-cycle hardware update wins below
      if (sw_wr) begin
        if (in_mode)
          host_mode_reg <= pwdata[0];
        else if (in_port)
          port_pipe_reg[a_port] <= pwdata[2:0];
        else if (in_ctrl) begin
          pid_reg[a_pipe] <= pwdata[1:0];
          auto_nak_reg[a_pipe] <= pwdata[`UPR_CTRL_AUTONAK_BIT];
          iso_reg[a_pipe] <= pwdata[`UPR_CTRL_ISO_BIT];
          if (pwdata[`UPR_CTRL_SEQUENCE_CLEAR_BIT])
            seq_reg[a_pipe] <= 1'b0;
          // the iso select written in this same access decides
          else if (pwdata[`UPR_CTRL_SEQUENCE_SET_BIT] &&
                   !is_iso(a_pipe, {8{pwdata[`UPR_CTRL_ISO_BIT]}}))
            seq_reg[a_pipe] <= 1'b1;
        end else if (in_max_packet_field)
          max_packet_field_reg[a_pipe] <= pwdata[MAX_PACKET_FIELD_W-1:0];
        else if (in_buf) begin
          start_blk_reg[a_pipe] <= pwdata[6:0];
          blk_cnt_reg[a_pipe] <= pwdata[`UPR_BUF_COUNT_LSB+4:`UPR_BUF_COUNT_LSB];
        end
      end
      rsp_code <= `UPR_RSP_NONE;
      rsp_store <= 1'b0;
      ready_evt <= 1'b0;
      not_ready_evt <= 1'b0;
      empty_evt <= 1'b0;
      if (sie_evt_valid) begin
        case (sie_evt_code)
          `UPR_EV_SETUP: begin
            if (!host_mode_reg) begin
              rsp_code <= `UPR_RSP_ACK;
              setup_reg <= sie_setup_data;
              pid_reg[0] <= `UPR_PID_NAK;
              seq_reg[0] <= 1'b0;
            end
          end
          `UPR_EV_IN_TOKEN: begin
            if (!host_mode_reg) begin
              if (ep_pid == `UPR_PID_STALL)
                rsp_code <= `UPR_RSP_STALL;
              else if (ep_pid != `UPR_PID_BUF)
                rsp_code <= `UPR_RSP_NAK;
              else if (ep_zero)
                rsp_code <= `UPR_RSP_ZLP;
              else if (ep_ready) begin
                rsp_code <= `UPR_RSP_DATA;
                rsp_seq <= seq_reg[ep];
              end else begin
                rsp_code <= `UPR_RSP_NAK;
                not_ready_evt <= 1'b1;
              end
            end
          end
          `UPR_EV_STATUS_IN: begin
            rsp_code <= `UPR_RSP_DATA;
            rsp_seq <= 1'b1;
            seq_reg[0] <= 1'b1;
          end
          `UPR_EV_OUT_DATA: begin
            if (!host_mode_reg) begin
              if (ep_pid == `UPR_PID_STALL)
                rsp_code <= `UPR_RSP_STALL;
              else if (ep_pid != `UPR_PID_BUF)
                rsp_code <= `UPR_RSP_NAK;
              else if (ep_zero || !ep_ready) begin
                rsp_code <= `UPR_RSP_NAK;
                not_ready_evt <= 1'b1;
              end else begin
                rsp_code <= `UPR_RSP_ACK;
                rsp_store <= 1'b1;
                ready_evt <= 1'b1;
                if (!ep_iso)
                  seq_reg[ep] <= ~seq_reg[ep];
                if (sie_short_pkt && ep_bulk && auto_nak_reg[ep])
                  pid_reg[ep] <= `UPR_PID_NAK;
              end
            end
          end
          `UPR_EV_HOST_RX_OK: begin
            if (host_mode_reg && ep_pid == `UPR_PID_BUF) begin
              rsp_code <= `UPR_RSP_ACK;
              rsp_store <= 1'b1;
              ready_evt <= 1'b1;
              if (!ep_iso)
                seq_reg[ep] <= ~seq_reg[ep];
              if (sie_short_pkt && ep_bulk && auto_nak_reg[ep])
                pid_reg[ep] <= `UPR_PID_NAK;
            end
          end
          `UPR_EV_ACK_RCVD: begin
            seq_reg[ep] <= ~seq_reg[ep];
            empty_evt <= !ep_zero;
          end
          `UPR_EV_STALL_RCVD: begin
            if (host_mode_reg)
              pid_reg[ep] <= `UPR_PID_STALL;
          end
          `UPR_EV_NO_REPLY, `UPR_EV_BAD_PACKET: begin
            if (host_mode_reg && !ep_iso)
              pid_reg[ep] <= `UPR_PID_NAK;
          end
          `UPR_EV_OVERSIZE: begin
            pid_reg[ep] <= `UPR_PID_STALL;
            if (!host_mode_reg)
              rsp_code <= `UPR_RSP_STALL;
          end
          `UPR_EV_STAGE_ERR: begin
            if (!host_mode_reg) begin
              pid_reg[ep] <= `UPR_PID_STALL;
              rsp_code <= `UPR_RSP_STALL;
            end
          end
          `UPR_EV_COUNT_END: begin
            if (ep_bulk && auto_nak_reg[ep])
              pid_reg[ep] <= `UPR_PID_NAK;
          end
          default: begin
            rsp_code <= `UPR_RSP_NONE;
          end
        endcase
      end
    end
  end

  // host token enables, cpu write blocks and port ready flags
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pipe
      always @(posedge ref_clk) begin
        if (!nrst) begin
          host_pipe_enable[g] <= 1'b0;
          cpu_write_block[g] <= 1'b0;
        end else begin
          host_pipe_enable[g] <= host_mode_reg && (pid_reg[g] == `UPR_PID_BUF);
          cpu_write_block[g] <= !host_mode_reg && is_bulk(g, iso_reg) &&
                                (max_packet_field_reg[g] == {MAX_PACKET_FIELD_W{1'b0}});
        end
      end
    end
    for (g = 0; g < NUM_PORTS; g = g + 1) begin : g_port
      always @(posedge ref_clk) begin
        if (!nrst)
          port_access_ready[g] <= 1'b0;
        else
          port_access_ready[g] <= buf_cpu_ready[port_pipe_reg[g]];
      end
    end
  endgenerate

endmodule // upr_pipe_ctrl
`default_nettype wire

// ==== upr_pipe_ctrl_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "upr_map.vh"
module upr_props (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic sie_evt_valid,
  input wire logic [3:0] sie_evt_code,
  input wire logic [2:0] sie_evt_pipe,
  input wire logic [2:0] rsp_code,
  input wire logic rsp_seq,
  input wire logic rsp_store,
  input wire logic ready_evt,
  input wire logic not_ready_evt,
  input wire logic empty_evt,
  input wire logic [7:0] host_pipe_enable
);
  logic host_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // tracks the host mode bit from completed writes
  always_ff @(posedge ref_clk) begin
    if (!nrst) host_q <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == `UPR_MODE_OFS) host_q <= pwdata[0];
  end
  sequence s_status;
    sie_evt_valid && sie_evt_code == `UPR_EV_STATUS_IN ##1 rsp_code == `UPR_RSP_DATA;
  endsequence
  a_apb_one_wait: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_setup_ack: assert property (!host_q && sie_evt_valid && sie_evt_code == `UPR_EV_SETUP
    |=> rsp_code == `UPR_RSP_ACK) else $error("setup not acknowledged");
  a_stall_stop: assert property (sie_evt_valid && sie_evt_code inside {`UPR_EV_STALL_RCVD,
    `UPR_EV_OVERSIZE} |-> ##2 !host_pipe_enable[$past(sie_evt_pipe, 2)])
    else $error("pipe not stopped");
  a_abort_nak: assert property (sie_evt_valid && sie_evt_code inside {`UPR_EV_NO_REPLY,
    `UPR_EV_BAD_PACKET} && sie_evt_pipe != 3'h1 && sie_evt_pipe != 3'h2
    |-> ##2 !host_pipe_enable[$past(sie_evt_pipe, 2)])
    else $error("pipe not stopped on abort");
  a_status_data1: assert property (s_status |-> rsp_seq)
    else $error("status reply not data1");
  a_zlp_quiet: assert property (rsp_code == `UPR_RSP_ZLP |-> !ready_evt && !not_ready_evt
    && !empty_evt) else $error("event with empty reply");
  a_store_ack: assert property (!host_q && rsp_store |-> rsp_code == `UPR_RSP_ACK)
    else $error("store without ack");
  a_idle_quiet: assert property (!sie_evt_valid |=> rsp_code == `UPR_RSP_NONE && !rsp_store)
    else $error("reply without event");
endmodule // upr_props
bind upr_pipe_ctrl upr_props u_props (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .sie_evt_valid, .sie_evt_code, .sie_evt_pipe, .rsp_code, .rsp_seq,
  .rsp_store, .ready_evt, .not_ready_evt, .empty_evt, .host_pipe_enable);
`default_nettype wire

// ==== upr_sie_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module upr_sie_model (
  input wire logic ref_clk,
  input wire logic [2:0] rsp_code,
  input wire logic not_ready_evt,
  output logic sie_evt_valid,
  output logic [3:0] sie_evt_code,
  output logic [2:0] sie_evt_pipe,
  output logic sie_short_pkt,
  output logic [63:0] sie_setup_data
);
  localparam logic [63:0] REQ = 64'h0009_0000_0001_0680;
  initial begin
    sie_evt_valid = 1'b0;
    sie_evt_code = 4'h0;
    sie_evt_pipe = 3'h0;
    sie_short_pkt = 1'b0;
    sie_setup_data = ~REQ;
  end
  // one event per call; request bytes are only meaningful beside it
  task send(input logic [3:0] c, input logic [2:0] p, input logic s, output logic [2:0] r,
    output logic n);
    @(posedge ref_clk);
    sie_evt_valid <= 1'b1;
    sie_evt_code <= c;
    sie_evt_pipe <= p;
    sie_short_pkt <= s;
    sie_setup_data <= REQ;
    @(posedge ref_clk);
    sie_evt_valid <= 1'b0;
    sie_setup_data <= ~REQ;
    @(posedge ref_clk);
    r = rsp_code;
    n = not_ready_evt;
  endtask
endmodule // upr_sie_model
`default_nettype wire

// ==== upr_pipe_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "upr_map.vh"
module upr_pipe_ctrl_tb;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, rsp_seq, rsp_store, er, nr;
  logic ready_evt, not_ready_evt, empty_evt, sie_evt_valid, sie_short_pkt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] sie_evt_code;
  logic [2:0] sie_evt_pipe, rsp_code, rs, port_access_ready;
  logic [63:0] sie_setup_data;
  logic [7:0] buf_sie_ready, buf_cpu_ready, host_pipe_enable, cpu_write_block;
  int error_cnt = 0;
  int samples_checked = 0;
  upr_pipe_ctrl DUT (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sie_evt_valid, .sie_evt_code, .sie_evt_pipe, .sie_short_pkt,
    .sie_setup_data, .buf_sie_ready, .buf_cpu_ready, .rsp_code, .rsp_seq, .rsp_store,
    .ready_evt, .not_ready_evt, .empty_evt, .host_pipe_enable, .cpu_write_block,
    .port_access_ready);
  upr_sie_model u_sie (.ref_clk, .rsp_code, .not_ready_evt, .sie_evt_valid, .sie_evt_code,
    .sie_evt_pipe, .sie_short_pkt, .sie_setup_data);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task results;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      results;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [11:0] ctl(input logic [2:0] p);
    return `UPR_PIPE_CTRL_OFS + {7'h0, p, 2'h0};
  endfunction
  task ev(input logic [3:0] c, input logic [2:0] p, input logic s);
    u_sie.send(c, p, s, rs, nr);
  endtask
  task settle;
    @(posedge ref_clk);
    #1;
  endtask
  initial begin
    #20000;
    error_cnt++;
    results;
  end
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    buf_sie_ready = 8'hff;
    buf_cpu_ready = 8'h08;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(0, ctl(3), 0); chk("pid3", rd, 32'h80);
    apb(0, 12'h3fc, 0); chk("slverr", er, 1);
    apb(1, `UPR_PIPE_MAX_PACKET_FIELD_OFS, 64); apb(0, `UPR_PIPE_MAX_PACKET_FIELD_OFS, 0);
    chk("mxp0", rd, 64);
    apb(1, `UPR_PIPE_MAX_PACKET_FIELD_OFS + 12'h004, 1024); apb(0, `UPR_PIPE_MAX_PACKET_FIELD_OFS + 12'h004, 0);
    chk("mxp1", rd, 1024);
    apb(1, `UPR_PIPE_MAX_PACKET_FIELD_OFS + 12'h018, 64); apb(0, `UPR_PIPE_MAX_PACKET_FIELD_OFS + 12'h018, 0);
    chk("mxp6", rd, 64);
    ev(`UPR_EV_OUT_DATA, 3, 0); chk("nak3", rs, `UPR_RSP_NAK);
    apb(1, ctl(3), `UPR_PID_STALL);
    ev(`UPR_EV_OUT_DATA, 3, 0); chk("stall3", rs, `UPR_RSP_STALL);
    apb(1, `UPR_PIPE_MAX_PACKET_FIELD_OFS + 12'h00c, 512);
    apb(1, ctl(3), `UPR_PID_BUF);
    ev(`UPR_EV_OUT_DATA, 3, 0); chk("ack3", rs, `UPR_RSP_ACK);
    apb(0, ctl(3), 0); chk("seq3", rd[4], 1);
    ev(`UPR_EV_IN_TOKEN, 3, 0); chk("din3", rs, `UPR_RSP_DATA);
    chk("dseq", rsp_seq, 1);
    ev(`UPR_EV_ACK_RCVD, 3, 0); apb(0, ctl(3), 0); chk("seqa", rd[4], 0);
    apb(1, ctl(3), 32'h21);
    ev(`UPR_EV_OUT_DATA, 3, 1); apb(0, ctl(3), 0); chk("short", rd[1:0], 0);
    apb(1, ctl(3), 32'h21);
    ev(`UPR_EV_COUNT_END, 3, 0); apb(0, ctl(3), 0); chk("cnt", rd[1:0], 0);
    apb(1, ctl(3), `UPR_PID_BUF);
    ev(`UPR_EV_OVERSIZE, 3, 0); apb(0, ctl(3), 0); chk("ovr", rd[1:0], 2);
    apb(1, ctl(4), `UPR_PID_BUF);
    ev(`UPR_EV_IN_TOKEN, 4, 0); chk("zlp", rs, `UPR_RSP_ZLP);
    chk("wblk", cpu_write_block[4], 1);
    apb(1, ctl(5), `UPR_PID_BUF);
    ev(`UPR_EV_OUT_DATA, 5, 0); chk("nak5", rs, `UPR_RSP_NAK);
    chk("not_ready_irq", nr, 1);
    ev(`UPR_EV_STAGE_ERR, 0, 0); chk("serr", rs, `UPR_RSP_STALL);
    apb(1, ctl(0), `UPR_PID_BUF);
    ev(`UPR_EV_SETUP, 0, 0); chk("sack", rs, `UPR_RSP_ACK);
    apb(0, `UPR_SETUP_LO_OFS, 0); chk("req", rd, u_sie.REQ[31:0]);
    apb(0, `UPR_SETUP_HI_OFS, 0); chk("req", rd, u_sie.REQ[63:32]);
    apb(0, ctl(0), 0); chk("pid0", rd[1:0], 0);
    chk("seq0", rd[4], 0);
    apb(1, ctl(0), `UPR_PID_BUF);
    ev(`UPR_EV_STATUS_IN, 0, 0); chk("sts", rs, `UPR_RSP_DATA);
    chk("sseq", rsp_seq, 1);
    apb(1, ctl(1), 32'h48); apb(0, ctl(1), 0); chk("iso", rd[4], 0);
    apb(1, `UPR_PIPE_BUF_OFS + 12'h00c, 32'h0806);
    apb(1, `UPR_PORT_SEL_OFS, 3); apb(0, `UPR_PORT_SEL_OFS, 0);
    chk("blk", rd[22:16], 6);
    chk("port_access_ready", rd[8], 1);
    settle; chk("par", port_access_ready, 3'b001);
    apb(1, ctl(0), 0); apb(1, ctl(4), 0); apb(1, ctl(5), 0);
    apb(1, `UPR_MODE_OFS, 1); apb(1, ctl(3), `UPR_PID_BUF);
    settle; chk("hen", host_pipe_enable, 8'h08);
    ev(`UPR_EV_HOST_RX_OK, 3, 0); chk("hrx", rs, `UPR_RSP_ACK);
    ev(`UPR_EV_STALL_RCVD, 3, 0); apb(0, ctl(3), 0); chk("hstl", rd[1:0], 2);
    apb(1, ctl(3), `UPR_PID_BUF);
    ev(`UPR_EV_NO_REPLY, 3, 0); apb(0, ctl(3), 0); chk("hnak", rd[1:0], 0);
    apb(1, ctl(3), `UPR_PID_BUF);
    ev(`UPR_EV_BAD_PACKET, 3, 0); apb(0, ctl(3), 0); chk("hbad", rd[1:0], 0);
    settle; chk("hoff", host_pipe_enable, 8'h00);
    results;
  end
endmodule // upr_pipe_ctrl_tb
`default_nettype wire
